// >>> fmpc_top.sv
// sampling-rate measurement, lock supervision and parity concealment
// Summary of operation
// - a PCM sample with a parity error is replaced by the last good sample of its channel.
// - a non-PCM sample (channel-status bit 1 set) passes through even with a parity error.
// - a fast or abrupt change of the frame period drops the lock state.
// - the rate is counted against a 24.576 MHz reference that the board must supply.
// - with the reference tied low no measurement is made.
// - the result is a plain reference edge count, so reference error scales it and the ranges.
// - the rate code comes only from the measured count, never from channel-status rate bits.
// - the result leaves the block as a two-bit code on two output pins.
// - code 11 means 31.2-32.8 kHz, 00 means 43-45.2 kHz and 01 means 46.8-49.2 kHz.
// - code 10 is shown while unlocked with a live reference, or locked with a rate in no range.
// - without any reference since reset the code stays at 00.
// - a stopped reference freezes the last code and measuring resumes when it returns.
// - a computed code is held until the next result, a loss of lock or reset.
// - the error output is the OR of unlocked state and a detected parity error.
// - biphase violations, bad frame lengths or missing preambles drop the lock state.
module fmpc_top import fmpc_pkg::*; #(
    parameter int LOCK_GOOD = LOCK_FRAMES,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // decoder line events
    input wire logic biphase_err,
    input wire logic frame_len_err,
    input wire logic preamble_miss,
    input wire logic frame_tick,
    // decoded subframes
    input wire logic sub_valid,
    output logic sub_ready,
    input wire logic [31:0] sub_word,
    input wire logic sub_chan,
    input wire logic cs_nonpcm,
    // reference pin
    input wire logic ref_osc_in,
    // processed samples
    output logic smp_valid,
    input wire logic smp_ready,
    output logic [SMP_W-1:0] smp_data,
    output logic smp_chan,
    // status pins
    output logic rate_code_hi,
    output logic rate_code_lo,
    output logic unlocked,
    output logic error_out
);
    localparam int GOOD_W = $clog2(LOCK_GOOD + 1);

    generate
        if (LOCK_GOOD < 1 || DEPTH < 2) begin : g_bad_param
            $error("lock frame count must be at least one and depth at least two");
        end
    endgenerate

    // ****************************************
    // reference sampling and presence
    // ****************************************
    logic ref_s;
    logic ref_d_r;
    logic ref_rise;
    logic [IDLE_W-1:0] ref_idle_r;
    logic ref_live;

    fmpc_sync #(.W(1)) u_ref_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .async_in(ref_osc_in),
        .sync_out(ref_s)
    );

    assign ref_rise = ref_s && !ref_d_r;
    // idle counter starts saturated, so nothing counts until a first edge
    assign ref_live = ref_idle_r < REF_LOSS_CYC;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ref_d_r <= 1'b0;
            ref_idle_r <= REF_LOSS_CYC;
        end else if (ce) begin
            ref_d_r <= ref_s;
            if (ref_rise) begin
                ref_idle_r <= '0;
            end else if (ref_live) begin
                ref_idle_r <= ref_idle_r + IDLE_W'(1);
            end
        end
    end

    // ****************************************
    // frame period and lock state
    // ****************************************
    logic [PERIOD_W-1:0] period_r;
    logic [PERIOD_W-1:0] prev_period_r;
    logic [PERIOD_W-1:0] period_diff;
    logic have_period_r;
    logic rate_jump;
    logic line_fault;
    logic [GOOD_W-1:0] good_r;

    assign period_diff = (period_r > prev_period_r) ? period_r - prev_period_r
                                                     : prev_period_r - period_r;
    assign rate_jump = frame_tick && have_period_r && period_diff > JUMP_TOL_CYC;
    assign line_fault = biphase_err || frame_len_err || preamble_miss || rate_jump;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            period_r <= '0;
            prev_period_r <= '0;
            have_period_r <= 1'b0;
        end else if (ce) begin
            if (frame_tick) begin
                period_r <= PERIOD_W'(1);
                prev_period_r <= period_r;
                have_period_r <= 1'b1;
            end else if (period_r != '1) begin
                period_r <= period_r + PERIOD_W'(1);
            end
        end
    end

    // any fault drops lock at once; a run of clean frames regains it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            unlocked <= 1'b1;
            good_r <= '0;
        end else if (ce) begin
            if (line_fault) begin
                unlocked <= 1'b1;
                good_r <= '0;
            end else if (frame_tick && unlocked) begin
                if (good_r == GOOD_W'(LOCK_GOOD - 1)) begin
                    unlocked <= 1'b0;
                    good_r <= '0;
                end else begin
                    good_r <= good_r + GOOD_W'(1);
                end
            end
        end
    end

    // ****************************************
    // rate measurement
    // ****************************************
    fmpc_meas_t meas_r;
    logic [CNT_W-1:0] ref_cnt_r;
    logic [FRAME_W-1:0] frames_r;
    logic win_done;
    logic [1:0] code_r;
    logic [1:0] code_meas;

    assign win_done = meas_r == MEAS_RUN && frame_tick && ref_live && !unlocked
        && frames_r == FRAME_W'(MEAS_FRAMES - 1);

    // only the measured edge count picks the code, channel-status rate bits are not looked at
    always_comb begin
        if (ref_cnt_r >= C32_MIN && ref_cnt_r <= C32_MAX) begin
            code_meas = CODE_32;
        end else if (ref_cnt_r >= C44_MIN && ref_cnt_r <= C44_MAX) begin
            code_meas = CODE_44;
        end else if (ref_cnt_r >= C48_MIN && ref_cnt_r <= C48_MAX) begin
            code_meas = CODE_48;
        end else begin
            code_meas = CODE_BAD;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meas_r <= MEAS_IDLE;
            ref_cnt_r <= '0;
            frames_r <= '0;
        end else if (ce) begin
            unique case (meas_r)
                MEAS_IDLE: begin
                    // windows start on a frame boundary with lock and a live reference
                    ref_cnt_r <= '0;
                    frames_r <= '0;
                    if (frame_tick && !unlocked && ref_live) begin
                        meas_r <= MEAS_RUN;
                    end
                end
                MEAS_RUN: begin
                    if (!ref_live) begin
                        meas_r <= MEAS_HOLD;
                    end else if (unlocked) begin
                        meas_r <= MEAS_IDLE;
                    end else if (win_done) begin
                        ref_cnt_r <= CNT_W'(ref_rise);
                        frames_r <= '0;
                    end else begin
                        // plain reference edge count: reference error shifts it one to one
                        if (ref_rise && ref_cnt_r != '1) begin
                            ref_cnt_r <= ref_cnt_r + CNT_W'(1);
                        end
                        if (frame_tick) begin
                            frames_r <= frames_r + FRAME_W'(1);
                        end
                    end
                end
                MEAS_HOLD: begin
                    if (ref_live) begin
                        meas_r <= MEAS_IDLE;
                    end
                end
            endcase
        end
    end

    // code changes only with a live reference, so it freezes without one
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            code_r <= CODE_RESET;
        end else if (ce && ref_live) begin
            if (unlocked) begin
                code_r <= CODE_BAD;
            end else if (win_done) begin
                code_r <= code_meas;
            end
        end
    end

    assign rate_code_hi = code_r[1];
    assign rate_code_lo = code_r[0];

    // ****************************************
    // parity check and concealment
    // ****************************************
    logic accept;
    logic par_bad;
    logic [SMP_W-1:0] smp_in;
    logic [SMP_W-1:0] prev_r [2];
    logic [SMP_W:0] wr_data;
    logic par_flag_r;
    logic fifo_valid;
    logic fifo_take;
    logic [SMP_W:0] fifo_data;

    assign accept = sub_valid && sub_ready;
    assign par_bad = ^sub_word[PAR_HI:PAR_LO];
    assign smp_in = sub_word[SMP_HI:SMP_LO];

    always_comb begin
        wr_data = {sub_chan, smp_in};
        if (par_bad && !cs_nonpcm) begin
            wr_data = {sub_chan, prev_r[sub_chan]};
        end
    end

    // a bad sample never becomes the substitute for the next one
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_r[0] <= '0;
            prev_r[1] <= '0;
        end else if (ce && accept && !par_bad) begin
            prev_r[sub_chan] <= smp_in;
        end
    end

    // a new parity event in the clearing cycle keeps the flag set
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            par_flag_r <= 1'b0;
        end else if (ce) begin
            if (accept && par_bad) begin
                par_flag_r <= 1'b1;
            end else if (frame_tick) begin
                par_flag_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            error_out <= 1'b1;
        end else if (ce) begin
            error_out <= unlocked || par_flag_r;
        end
    end

    // ****************************************
    // sample buffer and output register
    // ****************************************
    assign fifo_take = !smp_valid || smp_ready;

    fmpc_fifo #(.W(SMP_W + 1), .DEPTH(DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .in_valid(sub_valid),
        .in_ready(sub_ready),
        .in_data(wr_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_take),
        .out_data(fifo_data)
    );

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            smp_valid <= 1'b0;
            smp_data <= '0;
            smp_chan <= 1'b0;
        end else if (ce && fifo_take) begin
            smp_valid <= fifo_valid;
            if (fifo_valid) begin
                smp_data <= fifo_data[SMP_W-1:0];
                smp_chan <= fifo_data[SMP_W];
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_conceal;
        (accept && par_bad && !cs_nonpcm) |-> wr_data[SMP_W-1:0] == prev_r[sub_chan];
    endproperty
    a_conceal: assert property (p_conceal) else $error("pcm parity error not concealed");
    property p_nonpcm_pass;
        (accept && cs_nonpcm) |-> wr_data[SMP_W-1:0] == sub_word[SMP_HI:SMP_LO];
    endproperty
    a_nonpcm_pass: assert property (p_nonpcm_pass) else $error("non-pcm sample altered");
    property p_fault_unlock;
        (ce && line_fault) |=> unlocked;
    endproperty
    a_fault_unlock: assert property (p_fault_unlock) else $error("fault kept lock");
    property p_jump_unlock;
        (ce && frame_tick && have_period_r && period_diff > JUMP_TOL_CYC) |=> unlocked;
    endproperty
    a_jump_unlock: assert property (p_jump_unlock) else $error("rate jump kept lock");
    property p_unlock_code;
        (ce && unlocked && ref_live) |=> code_r == CODE_BAD;
    endproperty
    a_unlock_code: assert property (p_unlock_code) else $error("unlocked code not 10");
    property p_ref_freeze;
        (ce && !ref_live) |=> $stable(code_r);
    endproperty
    a_ref_freeze: assert property (p_ref_freeze) else $error("code moved without ref");
    property p_hold;
        (!(ce && ref_live && (unlocked || win_done))) |=> $stable(code_r);
    endproperty
    a_hold: assert property (p_hold) else $error("code moved without a result");
    property p_code48;
        (ce && win_done && ref_cnt_r >= C48_MIN && ref_cnt_r <= C48_MAX) |=> code_r == CODE_48;
    endproperty
    a_code48: assert property (p_code48) else $error("48k count gave wrong code");
    property p_code32;
        (ce && win_done && ref_cnt_r >= C32_MIN && ref_cnt_r <= C32_MAX) |=> code_r == CODE_32;
    endproperty
    a_code32: assert property (p_code32) else $error("32k count gave wrong code");
    property p_parity_flag;
        (ce && accept && par_bad) |=> par_flag_r ##1 (!ce || error_out);
    endproperty
    a_parity_flag: assert property (p_parity_flag) else $error("parity error not flagged");
    property p_error_or;
        ce |=> error_out == ($past(unlocked) || $past(par_flag_r));
    endproperty
    a_error_or: assert property (p_error_or) else $error("error output not the or");
    property p_noref_stop;
        (ce && !ref_live && meas_r == MEAS_RUN) |=> meas_r == MEAS_HOLD;
    endproperty
    a_noref_stop: assert property (p_noref_stop) else $error("counting without ref");
endmodule

// >>> fmpc_pkg.sv
// constants and types shared by the rate measurement and parity concealment block
package fmpc_pkg;

    // ****************************************
    // clock and reference
    // ****************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int REF_HZ = 24_576_000;

    // ****************************************
    // rate windows, in hertz
    // ****************************************
    localparam int RATE32_LO_HZ = 31_200;
    localparam int RATE32_HI_HZ = 32_800;
    localparam int RATE44_LO_HZ = 43_000;
    localparam int RATE44_HI_HZ = 45_200;
    localparam int RATE48_LO_HZ = 46_800;
    localparam int RATE48_HI_HZ = 49_200;

    // ****************************************
    // measurement window and count bounds
    // ****************************************
    localparam int MEAS_FRAMES = 8;
    localparam int FRAME_W = 3;
    localparam int CNT_W = 13;
    localparam int MEAS_REF = MEAS_FRAMES * REF_HZ;
    // higher rate gives fewer reference edges: low bound from the high rate, rounded up
    localparam logic [CNT_W-1:0] C32_MIN = CNT_W'((MEAS_REF + RATE32_HI_HZ - 1) / RATE32_HI_HZ);
    localparam logic [CNT_W-1:0] C32_MAX = CNT_W'(MEAS_REF / RATE32_LO_HZ);
    localparam logic [CNT_W-1:0] C44_MIN = CNT_W'((MEAS_REF + RATE44_HI_HZ - 1) / RATE44_HI_HZ);
    localparam logic [CNT_W-1:0] C44_MAX = CNT_W'(MEAS_REF / RATE44_LO_HZ);
    localparam logic [CNT_W-1:0] C48_MIN = CNT_W'((MEAS_REF + RATE48_HI_HZ - 1) / RATE48_HI_HZ);
    localparam logic [CNT_W-1:0] C48_MAX = CNT_W'(MEAS_REF / RATE48_LO_HZ);

    // ****************************************
    // rate codes, upper bit first
    // ****************************************
    localparam logic [1:0] CODE_RESET = 2'h0;
    localparam logic [1:0] CODE_32 = 2'h3;
    localparam logic [1:0] CODE_44 = 2'h0;
    localparam logic [1:0] CODE_48 = 2'h1;
    localparam logic [1:0] CODE_BAD = 2'h2;

    // ****************************************
    // timing
    // ****************************************
    localparam int REF_LOSS_NS = 1000;
    localparam int IDLE_W = 6;
    localparam logic [IDLE_W-1:0] REF_LOSS_CYC =
        IDLE_W'((REF_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int JUMP_TOL_NS = 400;
    localparam int PERIOD_W = 12;
    localparam logic [PERIOD_W-1:0] JUMP_TOL_CYC = PERIOD_W'(JUMP_TOL_NS / CLK_PERIOD_NS);
    localparam int LOCK_FRAMES = 16;

    // ****************************************
    // subframe layout
    // ****************************************
    localparam int PAR_LO = 4;
    localparam int PAR_HI = 31;
    localparam int SMP_LO = 4;
    localparam int SMP_HI = 27;
    localparam int SMP_W = 24;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [1:0] {MEAS_IDLE, MEAS_RUN, MEAS_HOLD} fmpc_meas_t;

endpackage

// >>> fmpc_sync.sv
// two flip-flop synchroniser for pin-level inputs
module fmpc_sync import fmpc_pkg::*; #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// >>> fmpc_fifo.sv
// flip-flop FIFO with valid/ready on both sides and registered flags
module fmpc_fifo import fmpc_pkg::*; #(
    parameter int W = SMP_W + 1,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("fifo depth must be a power of two, at least two");
        end
    endgenerate

    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_idx_r;
    logic [AW-1:0] rd_idx_r;
    logic [AW:0] count_r;
    logic [AW:0] count_nxt;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_r[rd_idx_r];

    always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + (AW+1)'(1);
        end else if (pop && !push) begin
            count_nxt = count_r - (AW+1)'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ce && push) begin
            mem_r[wr_idx_r] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_idx_r <= '0;
            rd_idx_r <= '0;
            count_r <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else if (ce) begin
            if (push) begin
                wr_idx_r <= wr_idx_r + AW'(1);
            end
            if (pop) begin
                rd_idx_r <= rd_idx_r + AW'(1);
            end
            count_r <= count_nxt;
            in_ready <= count_nxt != (AW+1)'(DEPTH);
            out_valid <= count_nxt != '0;
        end
    end
endmodule

// >>> fmpc_sink.sv
// sample sink model standing in for the host that drains processed samples
module fmpc_sink import fmpc_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bench control
    input wire logic stall,
    // sample stream
    input wire logic smp_valid,
    output logic smp_ready,
    input wire logic [SMP_W-1:0] smp_data,
    input wire logic smp_chan
);
    logic [SMP_W-1:0] data_q[$];
    logic chan_q[$];
    // stalling lets the fifo fill up so that its refusal shows
    assign smp_ready = !stall;
    always @(posedge sys_clk) begin
        if (!rst && smp_valid && smp_ready) begin
            data_q.push_back(smp_data);
            chan_q.push_back(smp_chan);
        end
    end
endmodule

// >>> test_fs_measure_and_parity_conceal.sv
// self-checking bench for the rate measurement and parity concealment block
module test_fs_measure_and_parity_conceal import fmpc_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 0, rst = 1, ref_en = 0, ref_osc_in = 0, stall = 0, rdy;
    logic biphase_err = 0, frame_len_err = 0, preamble_miss = 0, frame_tick = 0;
    logic sub_valid = 0, sub_chan = 0, cs_nonpcm = 0;
    logic [31:0] sub_word = 32'h0000_0000;
    logic sub_ready, smp_valid, smp_ready, smp_chan, rate_code_hi, rate_code_lo;
    logic unlocked, error_out;
    logic [SMP_W-1:0] smp_data;
    int err_total = 0, tests_run = 0, acc, base;
    typedef struct {logic [23:0] s; logic ch; logic np; logic bad; logic [23:0] e;} fmpc_row_t;
    fmpc_row_t rows[6];

    // ****************************************
    // clocks and instances
    // ****************************************
    initial forever #12.5 sys_clk = ~sys_clk;
    // reference slowed to a 3-cycle period so 40 MHz sampling sees every edge
    // offset keeps reference toggles off the sampling edges of sys_clk
    initial begin
        #5;
        forever begin
            #37.5;
            ref_osc_in = ref_en ? ~ref_osc_in : 1'b0;
        end
    end
    fmpc_top #(.LOCK_GOOD(2), .DEPTH(FIFO_DEPTH)) u_fmpc_top (
        .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .biphase_err(biphase_err),
        .frame_len_err(frame_len_err), .preamble_miss(preamble_miss), .frame_tick(frame_tick),
        .sub_valid(sub_valid), .sub_ready(sub_ready), .sub_word(sub_word), .sub_chan(sub_chan),
        .cs_nonpcm(cs_nonpcm), .ref_osc_in(ref_osc_in), .smp_valid(smp_valid),
        .smp_ready(smp_ready), .smp_data(smp_data), .smp_chan(smp_chan),
        .rate_code_hi(rate_code_hi), .rate_code_lo(rate_code_lo), .unlocked(unlocked),
        .error_out(error_out));
    fmpc_sink u_fmpc_sink (.sys_clk(sys_clk), .rst(rst), .stall(stall), .smp_valid(smp_valid),
        .smp_ready(smp_ready), .smp_data(smp_data), .smp_chan(smp_chan));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic ticks(input int n, input int p);
        repeat (n) begin
            step(p - 1);
            frame_tick = 1;
            step(1);
            frame_tick = 0;
        end
    endtask
    function automatic logic [31:0] mk(input logic [23:0] s, input logic bad);
        return {(^s) ^ bad, 3'b000, s, 4'h0};
    endfunction
    task automatic send(input logic [23:0] s, input logic ch, input logic np, input logic bad);
        logic r;
        sub_word = mk(s, bad);
        sub_chan = ch;
        cs_nonpcm = np;
        sub_valid = 1;
        do begin
            r = sub_ready;
            step(1);
        end while (!r);
        sub_valid = 0;
    endtask
    task automatic run_rate(input int p, input logic [1:0] code);
        ticks(1, p);
        step(2);
        chk(unlocked, 1, "unlock on rate jump");
        chk({rate_code_hi, rate_code_lo}, CODE_BAD, "code while unlocked");
        ticks(12, p);
        step(2);
        chk(unlocked, 0, "relock");
        chk(error_out, 0, "error clear when locked");
        chk({rate_code_hi, rate_code_lo}, code, "measured code");
        $display("rate test with frame period %0d done", p);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        rows = '{'{24'h12_3456, 1'b0, 1'b0, 1'b0, 24'h12_3456},
                 '{24'h65_4321, 1'b1, 1'b0, 1'b0, 24'h65_4321},
                 '{24'hAB_CDEF, 1'b0, 1'b0, 1'b1, 24'h12_3456},
                 '{24'h00_0001, 1'b1, 1'b0, 1'b1, 24'h65_4321},
                 '{24'hFF_FFFF, 1'b0, 1'b1, 1'b1, 24'hFF_FFFF},
                 '{24'h0F_0F0F, 1'b0, 1'b0, 1'b1, 24'h12_3456}};
        step(2);
        chk(sub_ready, 1, "ready in reset");
        chk(smp_valid, 0, "valid in reset");
        chk({rate_code_hi, rate_code_lo}, CODE_RESET, "code in reset");
        chk(unlocked, 1, "unlocked in reset");
        chk(error_out, 1, "error in reset");
        step(2);
        rst = 0;
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            send(rows[i].s, rows[i].ch, rows[i].np, rows[i].bad);
            step(4);
            chk(u_fmpc_sink.data_q[i], rows[i].e, "sample");
            chk(u_fmpc_sink.chan_q[i], rows[i].ch, "channel");
        end
        $display("concealment rows done");
        // fill until refused with the sink stalled, then drain
        stall = 1;
        base = u_fmpc_sink.data_q.size();
        acc = 0;
        sub_valid = 1;
        for (int k = 0; k < 20; k++) begin
            sub_word = mk(24'(acc + 1), 1'b0);
            rdy = sub_ready;
            step(1);
            if (rdy) acc++;
        end
        sub_valid = 0;
        chk(sub_ready, 0, "full fifo refuses");
        chk(acc >= FIFO_DEPTH && acc <= FIFO_DEPTH + 1, 1, "words taken before full");
        stall = 0;
        step(30);
        chk(24'(u_fmpc_sink.data_q.size() - base), 24'(acc), "words drained");
        for (int k = 0; k < acc; k++) chk(u_fmpc_sink.data_q[base + k], 24'(k + 1), "order");
        $display("fifo test done");
        for (int i = 0; i < 3; i++) begin
            ticks(5, 100);
            chk(unlocked, 0, "locked");
            {biphase_err, frame_len_err, preamble_miss} = 3'b100 >> i;
            step(1);
            {biphase_err, frame_len_err, preamble_miss} = 3'b000;
            chk(unlocked, 1, "unlock on line fault");
            step(1);
            chk(error_out, 1, "error on unlock");
            chk({rate_code_hi, rate_code_lo}, CODE_RESET, "code without reference");
        end
        $display("lock test done");
        ref_en = 1;
        run_rate(1537, CODE_48);
        send(24'h00_0000, 1'b0, 1'b0, 1'b1);
        step(2);
        chk(error_out, 1, "error on parity");
        run_rate(1673, CODE_44);
        run_rate(2305, CODE_32);
        ref_en = 0;
        step(60);
        preamble_miss = 1;
        step(1);
        preamble_miss = 0;
        step(3);
        chk({rate_code_hi, rate_code_lo}, CODE_32, "code frozen");
        ref_en = 1;
        run_rate(1000, CODE_BAD);
        report_and_stop();
    end
    initial begin
        repeat (100_000) @(posedge sys_clk);
        err_total++;
        $display("mismatch at %0t ns: watchdog expired", $time);
        report_and_stop();
    end
endmodule
